//--- hdl/bdm_data_memory.sv
// Banked data memory with direct and indirect access for the processor core.
// What this block does
// - Every data location holds eight bits.
// - Special area plus read-write general area.
// - Special locations in all banks; control 40H bank 1.
// - Bank select register picks general bank.
// - Address space starts at location 00H.
// - General ranges per bank and configuration.
// - Indirect ports act on pointed location.
// - Port zero bank 0; port one any bank.
// - Pointer at indirect port: zero, no write.
// - Field codes: 00,01,10 banks; 11 reserved.
// - Direct access reaches bank 0, and control 40H when bank 1 is selected.
// - Reset clears bank; watchdog power-down keeps it.
`timescale 1ns/1ps
`default_nettype none
`include "bdm_regs.svh"
module bdm_data_memory #(
  parameter bit THREE_BANKS = 1'b1,
  parameter int DEPTH       = 384
) (
  input  wire logic               CLK,
  input  wire logic               RST,
  input  wire logic [7:0]         ADDR,
  input  wire bdm_pkg::bdm_byte_t WDATA,
  input  wire logic               WR,
  input  wire logic               RD,
  output bdm_pkg::bdm_byte_t      RDATA,
  output bdm_pkg::bdm_bank_t      BANK,
  input  wire logic               WARM_RST,
  input  wire logic               WARM_KEEP_BANK,
  output logic                    EEC_WR,
  output bdm_pkg::bdm_byte_t      EEC_WDATA,
  output logic                    EEC_RD,
  input  wire bdm_pkg::bdm_byte_t EEC_RDATA
);
  import bdm_pkg::*;

  bdm_byte_t pointer_zero;
  bdm_byte_t pointer_one;
  bdm_bank_t bank_select;
  bdm_byte_t next_rdata;

  bdm_ram_if ram_bus ();

  // True when the location is general-purpose storage of the given bank.
  function automatic logic gp_hit(input logic [7:0] a, input bdm_bank_t b, input bit three);
    logic hit;
    hit = 1'b0;
    case (b)
      BDM_BANK0: hit = (a >= `BDM_GP0_LO) && (a <= `BDM_GP01_HI);
      BDM_BANK1: hit = (a >= `BDM_GPX_LO) && (a <= `BDM_GP01_HI);
      BDM_BANK2: hit = three && (a >= `BDM_GPX_LO) && (a <= `BDM_GP2_HI);
      default:   hit = 1'b0;
    endcase
    return hit;
  endfunction : gp_hit

  // Linear slot in the storage array; banks are packed one after another.
  function automatic bdm_index_t gp_index(input logic [7:0] a, input bdm_bank_t b);
    bdm_index_t idx;
    idx = '0;
    case (b)
      BDM_BANK0: idx = bdm_index_t'({1'b0, a} - {1'b0, `BDM_GP0_LO});
      BDM_BANK1: idx = `BDM_GP1_BASE + bdm_index_t'({1'b0, a} - {1'b0, `BDM_GPX_LO});
      BDM_BANK2: idx = `BDM_GP2_BASE + bdm_index_t'({1'b0, a} - {1'b0, `BDM_GPX_LO});
      default:   idx = '0;
    endcase
    return idx;
  endfunction : gp_index

  wire [7:0] addr_rel = ADDR - `BDM_ADDR_BASE;

  wire via_zero = (addr_rel == `BDM_ADDR_IND0);
  wire via_one  = (addr_rel == `BDM_ADDR_IND1);
  wire via_any  = via_zero || via_one;

  wire [7:0] eff_addr = via_zero ? pointer_zero : (via_one ? pointer_one : addr_rel);

  // Direct and port zero bank 0.
  wire bdm_bank_t eff_bank = via_one ? bank_select : BDM_BANK0;

  wire self_ref = via_any && ((eff_addr == `BDM_ADDR_IND0) || (eff_addr == `BDM_ADDR_IND1));

  wire hit_gp = !self_ref && gp_hit(eff_addr, eff_bank, THREE_BANKS);

  wire hit_ptr0 = !self_ref && (eff_addr == `BDM_ADDR_PTR0);
  wire hit_ptr1 = !self_ref && (eff_addr == `BDM_ADDR_PTR1);
  wire hit_bank = !self_ref && (eff_addr == `BDM_ADDR_BANKSEL);

  wire hit_eec = !self_ref && (eff_addr == `BDM_ADDR_EEC) && (bank_select == BDM_BANK1);

  assign ram_bus.we    = WR && hit_gp;
  assign ram_bus.waddr = gp_index(eff_addr, eff_bank);
  assign ram_bus.wdata = WDATA;
  assign ram_bus.raddr = gp_index(eff_addr, eff_bank);

  bdm_gp_ram #(
    .DEPTH (DEPTH)
  ) u_ram (
    .clk  (CLK),
    .port (ram_bus.ram)
  );

  bdm_bank_ctrl #(
    .THREE_BANKS (THREE_BANKS)
  ) u_bank (
    .clk       (CLK),
    .rst       (RST),
    .wr        (WR && hit_bank),
    .wdata     (WDATA),
    .warm_rst  (WARM_RST),
    .warm_keep (WARM_KEEP_BANK),
    .bank      (bank_select)
  );

  always_comb begin
    next_rdata = `BDM_ZERO_BYTE;
    if (hit_gp) begin
      next_rdata = ram_bus.rdata;
    end else if (hit_ptr0) begin
      next_rdata = pointer_zero;
    end else if (hit_ptr1) begin
      next_rdata = pointer_one;
    end else if (hit_bank) begin
      next_rdata = bdm_byte_t'({6'h00, bank_select});
    end else if (hit_eec) begin
      next_rdata = EEC_RDATA;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pointer_zero <= `BDM_PTR_RST;
      pointer_one  <= `BDM_PTR_RST;
    end else begin
      if (WR && hit_ptr0) begin
        pointer_zero <= WDATA;
      end
      if (WR && hit_ptr1) begin
        pointer_one <= WDATA;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RDATA <= `BDM_ZERO_BYTE;
    end else if (RD) begin
      RDATA <= next_rdata;
    end else begin
      RDATA <= `BDM_ZERO_BYTE;
    end
  end

  // The control register lives in the EEPROM block; accesses are passed on one cycle late.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      EEC_WR    <= 1'b0;
      EEC_RD    <= 1'b0;
      EEC_WDATA <= `BDM_ZERO_BYTE;
      BANK      <= BDM_BANK0;
    end else begin
      EEC_WR    <= WR && hit_eec;
      EEC_RD    <= RD && hit_eec;
      EEC_WDATA <= WDATA;
      BANK      <= bank_select;
    end
  end
endmodule : bdm_data_memory
`default_nettype wire

//--- shared/bdm_regs.svh
// Address map and reset constants of the banked data memory.
`ifndef BDM_REGS_SVH
`define BDM_REGS_SVH

`define BDM_ADDR_IND0     8'h00
`define BDM_ADDR_PTR0     8'h01
`define BDM_ADDR_IND1     8'h02
`define BDM_ADDR_PTR1     8'h03
`define BDM_ADDR_BANKSEL  8'h04
`define BDM_ADDR_EEC      8'h40
`define BDM_ADDR_BASE     8'h00
`define BDM_GP0_LO        8'h60
`define BDM_GPX_LO        8'h80
`define BDM_GP01_HI       8'hFF
`define BDM_GP2_HI        8'hDF
`define BDM_GP1_BASE      9'h0A0
`define BDM_GP2_BASE      9'h120
`define BDM_DEPTH_SMALL   288
`define BDM_DEPTH_LARGE   384
`define BDM_ZERO_BYTE     8'h00
`define BDM_PTR_RST       8'h00
`define BDM_BANK_RST      2'h0
`define BDM_BANK_LOW_BIT  0

`endif

//--- shared/bdm_pkg.sv
// Types shared by the banked data memory modules.
package bdm_pkg;
  typedef logic [7:0] bdm_byte_t;
  typedef logic [8:0] bdm_index_t;
  typedef enum logic [1:0] {
    BDM_BANK0     = 2'h0,
    BDM_BANK1     = 2'h1,
    BDM_BANK2     = 2'h2,
    BDM_BANK_RSVD = 2'h3
  } bdm_bank_t;
endpackage : bdm_pkg

//--- shared/bdm_ram_if.sv
// Port between the access logic and the general-purpose storage array.
`timescale 1ns/1ps
`default_nettype none
interface bdm_ram_if;
  import bdm_pkg::*;
  logic       we;
  bdm_index_t waddr;
  bdm_byte_t  wdata;
  bdm_index_t raddr;
  bdm_byte_t  rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport ram  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : bdm_ram_if
`default_nettype wire

//--- hdl/bdm_gp_ram.sv
// General-purpose storage array of all banks, one byte per location.
`timescale 1ns/1ps
`default_nettype none
`include "bdm_regs.svh"
module bdm_gp_ram #(
  parameter int DEPTH = 384
) (
  input  wire logic clk,
  bdm_ram_if.ram    port
);
  import bdm_pkg::*;

  // Storage is volatile and carries no reset, as in the real array.
  bdm_byte_t mem [DEPTH];

  wire in_range_w = (32'(port.waddr) < DEPTH);
  wire in_range_r = (32'(port.raddr) < DEPTH);

  always_ff @(posedge clk) begin
    if (port.we && in_range_w) begin
      mem[port.waddr] <= port.wdata;
    end
  end

  assign port.rdata = in_range_r ? mem[port.raddr] : `BDM_ZERO_BYTE;
endmodule : bdm_gp_ram
`default_nettype wire

//--- hdl/bdm_bank_ctrl.sv
// Bank select register with its full and warm reset behaviour.
`timescale 1ns/1ps
`default_nettype none
`include "bdm_regs.svh"
module bdm_bank_ctrl #(
  parameter bit THREE_BANKS = 1'b1
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              wr,
  input  wire bdm_pkg::bdm_byte_t wdata,
  input  wire logic              warm_rst,
  input  wire logic              warm_keep,
  output bdm_pkg::bdm_bank_t     bank
);
  import bdm_pkg::*;

  bdm_bank_t next_bank;

  // The smaller part keeps only the low bit of the field.
  wire [1:0] field = THREE_BANKS ? wdata[1:0] : {1'b0, wdata[`BDM_BANK_LOW_BIT]};

  always_comb begin
    next_bank = bank;
    if (warm_rst && !warm_keep) begin
      next_bank = bdm_bank_t'(`BDM_BANK_RST);
    end else if (wr) begin
      next_bank = bdm_bank_t'(field);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bank <= bdm_bank_t'(`BDM_BANK_RST);
    end else begin
      bank <= next_bank;
    end
  end
endmodule : bdm_bank_ctrl
`default_nettype wire

//--- shared/unused_placeholder_never.sv
// Empty compilation unit.

//--- sim/bdm_eec_model.sv
// Stand-in for the block that owns the control register at 40H.
`timescale 1ns/1ps
`default_nettype none
module bdm_eec_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr,
  input wire bdm_pkg::bdm_byte_t wdata,
  output bdm_pkg::bdm_byte_t rdata
);
  import bdm_pkg::*;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rdata <= 8'h00;
    else if (wr) rdata <= wdata;
  end
endmodule : bdm_eec_model
`default_nettype wire

//--- sim/bdm_data_memory_chk.sv
// Port assertions for the banked data memory.
`timescale 1ns/1ps
`default_nettype none
module bdm_data_memory_chk #(
  parameter bit THREE_BANKS = 1'b1,
  parameter int DEPTH = 384
) (
  input wire logic CLK, RST, WR, RD, WARM_RST, WARM_KEEP_BANK, EEC_WR, EEC_RD,
  input wire logic [7:0] ADDR,
  input wire bdm_pkg::bdm_byte_t WDATA, RDATA, EEC_WDATA, EEC_RDATA,
  input wire bdm_pkg::bdm_bank_t BANK
);
  import bdm_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00) else $error("idle read data");
  a_eec_wr_gate: assert property ($past(WR) && $past(ADDR) == 8'h40 |-> EEC_WR == (BANK == BDM_BANK1))
    else $error("control write gate");
  a_eec_wdata: assert property (EEC_WR |-> EEC_WDATA == $past(WDATA)) else $error("control write data");
  a_eec_rd_gate: assert property ($past(RD) && $past(ADDR) == 8'h40 |-> EEC_RD == (BANK == BDM_BANK1))
    else $error("control read gate");
  a_bank_value: assert property ($past(WR, 2) && $past(ADDR, 2) == 8'h04 && !$past(WARM_RST, 2)
    |-> BANK == (THREE_BANKS ? $past(WDATA[1:0], 2) : {1'b0, $past(WDATA[0], 2)})) else $error("bank value");
  a_warm_clear: assert property ($past(WARM_RST, 2) && !$past(WARM_KEEP_BANK, 2) |-> BANK == BDM_BANK0)
    else $error("warm clear");
  a_warm_keep: assert property ($past(WARM_RST, 2) && $past(WARM_KEEP_BANK, 2) && !$past(WR, 2) |-> $stable(BANK))
    else $error("warm keep");
  a_bank_read: assert property ($past(RD) && $past(ADDR) == 8'h04 |-> RDATA == {6'h00, BANK})
    else $error("bank readback");
  c_eec_wr: cover property (EEC_WR);
  c_eec_rd: cover property (EEC_RD);
  c_bank2: cover property (BANK == BDM_BANK2);
endmodule : bdm_data_memory_chk
bind bdm_data_memory bdm_data_memory_chk #(.THREE_BANKS(THREE_BANKS), .DEPTH(DEPTH)) u_chk (.*);
`default_nettype wire

//--- sim/bdm_data_memory_tb.sv
// Random and corner-case bench for the banked data memory.
`timescale 1ns/1ps
`default_nettype none
module bdm_data_memory_tb;
  import bdm_pkg::*;
  logic CLK = 0, RST = 1, WR = 0, RD = 0, WARM_RST = 0, WARM_KEEP_BANK = 0, EEC_WR, EEC_RD;
  logic [7:0] ADDR = 8'h00;
  bdm_byte_t WDATA = 8'h00, RDATA, EEC_WDATA, EEC_RDATA, ptr0, ptr1, ee, een, pexp;
  bdm_bank_t BANK;
  bdm_byte_t mem [1024];
  logic [1:0] bnk;
  int n_mismatch = 0, compares = 0, seed = 10, pend = 0;
  logic [7:0] hot [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h40, 8'h60, 8'hFF};
  // Each entry is kind (0 read, 1 write, 2 warm reset, 3 idle), address and data.
  logic [17:0] cor [18] = '{18'h10102, 18'h100A5, 18'h00000, 18'h10300, 18'h00200, 18'h10401, 18'h1403C,
    18'h04000, 18'h04000, 18'h08000, 18'h20001, 18'h00400, 18'h20000, 18'h00400, 18'h04000, 18'h10403,
    18'h00400, 18'h30000};
  always #50 CLK = ~CLK;
  bdm_data_memory uut (.*);
  bdm_eec_model eec (.clk(CLK), .rst(RST), .wr(EEC_WR), .wdata(EEC_WDATA), .rdata(EEC_RDATA));
  function automatic bit gp(input logic [9:0] x);
    return x[9:8] == 2'h0 ? x[7:0] >= 8'h60 : x[9:8] == 2'h1 ? x[7] : x[9:8] == 2'h2 && x[7] && x[7:0] <= 8'hDF;
  endfunction : gp
  task automatic chk(input bdm_byte_t got, input bdm_byte_t exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t read %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  // One bus cycle; a read is checked at the start of the following call.
  task automatic op(input int k, input logic [7:0] a, input bdm_byte_t d);
    logic [10:0] w;
    w = a == 8'h00 ? {ptr0 == 8'h00 || ptr0 == 8'h02, 2'h0, ptr0}
      : a == 8'h02 ? {ptr1 == 8'h00 || ptr1 == 8'h02, bnk, ptr1} : {3'h0, a};
    @(posedge CLK);
    WR <= k == 1;
    RD <= k == 0;
    WARM_RST <= k == 2;
    WARM_KEEP_BANK <= d[0];
    ADDR <= a;
    WDATA <= d;
    #1;
    if (pend) chk(RDATA, pexp);
    pend = k == 0;
    pexp = w[10] ? 8'h00 : w[7:0] == 8'h01 ? ptr0 : w[7:0] == 8'h03 ? ptr1 : w[7:0] == 8'h04 ? {6'h00, bnk}
      : w[7:0] == 8'h40 ? (bnk == 2'h1 ? ee : 8'h00) : gp(w[9:0]) ? mem[w[9:0]] : 8'h00;
    ee = een;
    if (k == 2 && !d[0]) bnk = 2'h0;
    if (k == 1 && !w[10]) begin
      if (w[7:0] == 8'h01) ptr0 = d;
      else if (w[7:0] == 8'h03) ptr1 = d;
      else if (w[7:0] == 8'h04) bnk = d[1:0];
      else if (w[7:0] == 8'h40) een = bnk == 2'h1 ? d : een;
      else if (gp(w[9:0])) mem[w[9:0]] = d;
    end
  endtask : op
  task automatic reset(input int n);
    @(posedge CLK);
    RST <= 1'b1;
    repeat (n) @(posedge CLK);
    RST <= 1'b0;
    {ptr0, ptr1, bnk, ee, een, pend} = '0;
  endtask : reset
  initial begin
    #1000000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    int i;
    reset(10);
    for (i = 0; i < 1024; i++) begin
      if (gp(i[9:0])) begin
        op(1, 8'h04, {6'h00, i[9:8]});
        op(1, 8'h03, i[7:0]);
        op(1, 8'h02, i[7:0] ^ 8'h5A);
      end
    end
    $display("fill done");
    foreach (cor[j]) op(cor[j][17:16], cor[j][15:8], cor[j][7:0]);
    $display("corner cases done");
    repeat (800) begin
      i = $random(seed);
      op(i[1:0], i[8] ? hot[i[4:2]] : i[16:9], i[31:24]);
    end
    op(3, 8'h00, 8'h00);
    reset(3);
    op(0, 8'h04, 8'h00);
    op(0, 8'h01, 8'h00);
    op(0, 8'h60, 8'h00);
    op(3, 8'h00, 8'h00);
    $display("random and reset done");
    tally_and_finish();
  end
endmodule : bdm_data_memory_tb
`default_nettype wire
